// File: core/vmon_top.sv
// Overview of operation
// RULE1 - separate UV and OV monitor per regulator
// RULE2 - per-regulator UV threshold code, 95 to 89 %
// RULE3 - per-regulator OV threshold code, 105 to 111 %
// RULE4 - shared UV debounce: 5/15/25/40 us
// RULE5 - UV debounce select resets to 10
// RULE6 - shared OV debounce: 25/50/80/125 us
// RULE7 - OV debounce select resets to 00
// RULE8 - enable bit turns both monitors on
// RULE9 - all enable bits reset to one
// RULE10 - secure mode: only secure writes change enables
// RULE11 - monitor masked until regulator in regulation
// RULE12 - disabling monitor clears its status indicators
// RULE13 - comparator ignored during 30 us settling
// RULE14 - debounce timing from the fixed control clock
// RULE15 - status sets after continuous debounce time
//
// Chosen here: the strobed register port and the register addresses.
module vmon_top #(
    parameter int LOW_DB_CYC0  = vmon_pkg::LOW_DB_CYC0,
    parameter int LOW_DB_CYC1  = vmon_pkg::LOW_DB_CYC1,
    parameter int LOW_DB_CYC2  = vmon_pkg::LOW_DB_CYC2,
    parameter int LOW_DB_CYC3  = vmon_pkg::LOW_DB_CYC3,
    parameter int HIGH_DB_CYC0 = vmon_pkg::HIGH_DB_CYC0,
    parameter int HIGH_DB_CYC1 = vmon_pkg::HIGH_DB_CYC1,
    parameter int HIGH_DB_CYC2 = vmon_pkg::HIGH_DB_CYC2,
    parameter int HIGH_DB_CYC3 = vmon_pkg::HIGH_DB_CYC3,
    parameter int SETTLE_CYC   = vmon_pkg::SETTLE_CYC
) (
    input  logic                             MCLK_I,
    input  logic                             RST_B_I,
    input  logic [vmon_pkg::ADDR_W-1:0]      ADDR_I,
    input  logic [vmon_pkg::DATA_W-1:0]      WDATA_I,
    input  logic                             WR_I,
    input  logic                             RD_I,
    input  logic                             SECURE_WR_I,
    input  logic                             SECURE_EN_I,
    input  logic [vmon_pkg::NUM_REG-1:0]     REG_ON_I,
    input  logic [vmon_pkg::NUM_REG-1:0]     REG_READY_I,
    input  logic [vmon_pkg::NUM_REG-1:0]     UV_CMP_I,
    input  logic [vmon_pkg::NUM_REG-1:0]     OV_CMP_I,
    output logic [vmon_pkg::DATA_W-1:0]      RDATA_O,
    output logic [2*vmon_pkg::NUM_REG-1:0]   UV_TH_O,
    output logic [2*vmon_pkg::NUM_REG-1:0]   OV_TH_O,
    output logic [vmon_pkg::NUM_REG-1:0]     UV_STATUS_O,
    output logic [vmon_pkg::NUM_REG-1:0]     OV_STATUS_O,
    output logic                             IRQ_O
);
    import vmon_pkg::*;

    typedef struct packed {
        logic [NUM_REG-1:0]   enable;
        logic [2*NUM_REG-1:0] low_th;
        logic [2*NUM_REG-1:0] high_th;
        logic [1:0]           low_db;
        logic [1:0]           high_db;
        logic [2*NUM_REG-1:0] irq_stat;
        logic [2*NUM_REG-1:0] irq_mask;
        logic [2*NUM_REG-1:0] st_prev;
        logic [DATA_W-1:0]    rdata;
    } top_state_t;

    localparam top_state_t TOP_RST = '{
        enable:   ENABLE_RST,
        low_th:   LOW_TH_RST,
        high_th:  HIGH_TH_RST,
        low_db:   LOW_DB_RST,
        high_db:  HIGH_DB_RST,
        irq_stat: '0,
        irq_mask: '0,
        st_prev:  '0,
        rdata:    '0
    };

    top_state_t             r_reg;
    top_state_t             r_next;
    logic [NUM_REG-1:0]     uv_s;
    logic [NUM_REG-1:0]     ov_s;
    logic [2*NUM_REG-1:0]   status;
    logic [2*NUM_REG-1:0]   evt;
    logic [CNT_W-1:0]       low_db_cnt;
    logic [CNT_W-1:0]       high_db_cnt;
    logic                   enable_wr_ok;
    logic                   enable_wr;

    // four-way pick of a debounce count from its select code
    function automatic logic [CNT_W-1:0] pick_count(
        input logic [1:0] sel,
        input int         c0,
        input int         c1,
        input int         c2,
        input int         c3
    );
        case (sel)
            2'h0:    pick_count = CNT_W'(c0);
            2'h1:    pick_count = CNT_W'(c1);
            2'h2:    pick_count = CNT_W'(c2);
            default: pick_count = CNT_W'(c3);
        endcase
    endfunction

    // debounce counts in control-clock cycles
    assign low_db_cnt  = pick_count(r_reg.low_db, LOW_DB_CYC0, LOW_DB_CYC1,
                                    LOW_DB_CYC2, LOW_DB_CYC3); // RULE4 RULE14
    assign high_db_cnt = pick_count(r_reg.high_db, HIGH_DB_CYC0, HIGH_DB_CYC1,
                                    HIGH_DB_CYC2, HIGH_DB_CYC3); // RULE6 RULE14

    // one monitor pair per regulator
    for (genvar g = 0; g < NUM_REG; g++) begin : g_chan // RULE1
        vmon_chan #(
            .CNT_W      (CNT_W),
            .SETTLE_CYC (SETTLE_CYC)
        ) u_chan (
            .clk_i       (MCLK_I),
            .rst_b_i     (RST_B_I),
            .enable_i    (r_reg.enable[g]), // RULE8
            .reg_on_i    (REG_ON_I[g]),
            .reg_ready_i (REG_READY_I[g]),
            .uv_cmp_i    (UV_CMP_I[g]),
            .ov_cmp_i    (OV_CMP_I[g]),
            .low_db_i    (low_db_cnt),
            .high_db_i   (high_db_cnt),
            .uv_s_o      (uv_s[g]),
            .ov_s_o      (ov_s[g])
        );
    end

    // status vector and its rising edges as interrupt events
    assign status = {ov_s, uv_s};
    assign evt    = status & ~r_reg.st_prev;

    // enable writes need the secure qualifier in secure mode
    assign enable_wr    = WR_I && (ADDR_I == ENABLE_OFS);
    assign enable_wr_ok = !SECURE_EN_I || SECURE_WR_I; // RULE10

    // outputs
    assign RDATA_O     = r_reg.rdata;
    assign UV_TH_O     = r_reg.low_th; // RULE2
    assign OV_TH_O     = r_reg.high_th; // RULE3
    assign UV_STATUS_O = uv_s;
    assign OV_STATUS_O = ov_s;
    assign IRQ_O       = |(r_reg.irq_stat & r_reg.irq_mask);

    // register writes, sticky events and read data
    always_comb begin
        r_next         = r_reg;
        r_next.st_prev = status;
        r_next.rdata   = '0;
        if (WR_I) begin
            case (ADDR_I)
                ENABLE_OFS: begin
                    if (enable_wr_ok) begin
                        r_next.enable = WDATA_I[NUM_REG-1:0]; // RULE8 RULE10
                    end
                end
                THRESH_OFS: begin
                    r_next.low_th  = WDATA_I[LOW_TH_POS +: 2*NUM_REG]; // RULE2
                    r_next.high_th = WDATA_I[HIGH_TH_POS +: 2*NUM_REG]; // RULE3
                end
                DEBOUNCE_OFS: begin
                    r_next.low_db  = WDATA_I[LOW_DB_POS +: 2]; // RULE4
                    r_next.high_db = WDATA_I[HIGH_DB_POS +: 2]; // RULE6
                end
                IRQ_STAT_OFS: begin
                    r_next.irq_stat = r_reg.irq_stat & ~WDATA_I[2*NUM_REG-1:0];
                end
                IRQ_MASK_OFS: begin
                    r_next.irq_mask = WDATA_I[2*NUM_REG-1:0];
                end
                default: begin
                end
            endcase
        end
        // a new event wins over a clear in the same cycle
        r_next.irq_stat = r_next.irq_stat | evt;
        if (RD_I) begin
            case (ADDR_I)
                ENABLE_OFS: begin
                    r_next.rdata[NUM_REG-1:0] = r_reg.enable;
                end
                THRESH_OFS: begin
                    r_next.rdata[LOW_TH_POS +: 2*NUM_REG]  = r_reg.low_th;
                    r_next.rdata[HIGH_TH_POS +: 2*NUM_REG] = r_reg.high_th;
                end
                DEBOUNCE_OFS: begin
                    r_next.rdata[LOW_DB_POS +: 2]  = r_reg.low_db;
                    r_next.rdata[HIGH_DB_POS +: 2] = r_reg.high_db;
                end
                STATUS_OFS: begin
                    r_next.rdata[UV_POS +: NUM_REG] = uv_s;
                    r_next.rdata[OV_POS +: NUM_REG] = ov_s;
                end
                IRQ_STAT_OFS: begin
                    r_next.rdata[2*NUM_REG-1:0] = r_reg.irq_stat;
                end
                IRQ_MASK_OFS: begin
                    r_next.rdata[2*NUM_REG-1:0] = r_reg.irq_mask;
                end
                default: begin
                    r_next.rdata = '0;
                end
            endcase
        end
    end

    // state register, reset loads the documented defaults
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            r_reg <= TOP_RST; // RULE5 RULE7 RULE9
        end else begin
            r_reg <= r_next;
        end
    end

    // ordinary write cannot move an enable in secure mode
    a_secure_reject: assert property ( // RULE10
        @(posedge MCLK_I) disable iff (!RST_B_I)
        enable_wr && SECURE_EN_I && !SECURE_WR_I |=> $stable(r_reg.enable))
        else $error("enable changed by ordinary write in secure mode");

    // accepted enable write lands next cycle
    a_enable_write: assert property ( // RULE8
        @(posedge MCLK_I) disable iff (!RST_B_I)
        enable_wr && enable_wr_ok |=> r_reg.enable == $past(WDATA_I[NUM_REG-1:0]))
        else $error("accepted enable write not stored");

    // UV debounce select after reset
    a_low_db_reset: assert property ( // RULE5
        @(posedge MCLK_I) disable iff (!RST_B_I)
        $rose(RST_B_I) |-> r_reg.low_db == 2'h2)
        else $error("UV debounce select wrong after reset");

    // OV debounce select after reset
    a_high_db_reset: assert property ( // RULE7
        @(posedge MCLK_I) disable iff (!RST_B_I)
        $rose(RST_B_I) |-> r_reg.high_db == 2'h0)
        else $error("OV debounce select wrong after reset");

    // all monitors enabled after reset
    a_enable_reset: assert property ( // RULE9
        @(posedge MCLK_I) disable iff (!RST_B_I)
        $rose(RST_B_I) |-> r_reg.enable == 8'hff)
        else $error("monitor enables not all set after reset");

    // debounce code 00 selects the shortest UV count
    a_low_db_map: assert property ( // RULE4
        @(posedge MCLK_I) disable iff (!RST_B_I)
        WR_I && ADDR_I == DEBOUNCE_OFS && WDATA_I[1:0] == 2'h0 |=> low_db_cnt == CNT_W'(LOW_DB_CYC0))
        else $error("UV debounce count not following select");

    // unmasked event raises interrupt the next cycle
    a_irq_raise: assert property (
        @(posedge MCLK_I) disable iff (!RST_B_I)
        |(evt & r_reg.irq_mask) |=> IRQ_O)
        else $error("interrupt not raised on unmasked event");

    c_secure_reject: cover property (
        @(posedge MCLK_I) disable iff (!RST_B_I) enable_wr && !enable_wr_ok);
    c_irq_clear: cover property (
        @(posedge MCLK_I) disable iff (!RST_B_I) IRQ_O ##1 !IRQ_O);
endmodule // vmon_top

// File: core/vmon_pkg.sv
package vmon_pkg;
    // regulator count: five bucks in the low bits, then three linear
    localparam int NUM_BUCK = 5;
    localparam int NUM_LIN  = 3;
    localparam int NUM_REG  = NUM_BUCK + NUM_LIN;
    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 32;
    localparam int CNT_W    = 15;

    // register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] ENABLE_OFS   = 8'h00;
    localparam logic [ADDR_W-1:0] THRESH_OFS   = 8'h04;
    localparam logic [ADDR_W-1:0] DEBOUNCE_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] STATUS_OFS   = 8'h0c;
    localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 8'h10;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 8'h14;

    // field positions
    localparam int LOW_TH_POS  = 0;
    localparam int HIGH_TH_POS = 16;
    localparam int LOW_DB_POS  = 0;
    localparam int HIGH_DB_POS = 2;
    localparam int UV_POS      = 0;
    localparam int OV_POS      = 8;

    // threshold codes: low 00..11 = 95/93/91/89 %, high 00..11 = 105/107/109/111 %
    localparam logic [1:0] buck_low_threshold_default    = 2'h0;
    localparam logic [1:0] linear_low_threshold_default  = 2'h0;
    localparam logic [1:0] buck_high_threshold_default   = 2'h0;
    localparam logic [1:0] linear_high_threshold_default = 2'h0;

    // reset values
    localparam logic [NUM_REG-1:0]   ENABLE_RST  = 8'hff;
    localparam logic [1:0]           LOW_DB_RST  = 2'h2;
    localparam logic [1:0]           HIGH_DB_RST = 2'h0;
    localparam logic [2*NUM_REG-1:0] LOW_TH_RST  =
        {{NUM_LIN{linear_low_threshold_default}}, {NUM_BUCK{buck_low_threshold_default}}};
    localparam logic [2*NUM_REG-1:0] HIGH_TH_RST =
        {{NUM_LIN{linear_high_threshold_default}}, {NUM_BUCK{buck_high_threshold_default}}};

    // timing in microseconds and the clock rate
    localparam int CLK_MHZ      = 200;
    localparam int SLOW_CLK_KHZ = 100;
    localparam int LOW_DB_US0   = 5;
    localparam int LOW_DB_US1   = 15;
    localparam int LOW_DB_US2   = 25;
    localparam int LOW_DB_US3   = 40;
    localparam int HIGH_DB_US0  = 25;
    localparam int HIGH_DB_US1  = 50;
    localparam int HIGH_DB_US2  = 80;
    localparam int HIGH_DB_US3  = 125;
    localparam int SETTLE_US    = 30;

    // derived cycle counts
    localparam int LOW_DB_CYC0  = LOW_DB_US0 * CLK_MHZ;
    localparam int LOW_DB_CYC1  = LOW_DB_US1 * CLK_MHZ;
    localparam int LOW_DB_CYC2  = LOW_DB_US2 * CLK_MHZ;
    localparam int LOW_DB_CYC3  = LOW_DB_US3 * CLK_MHZ;
    localparam int HIGH_DB_CYC0 = HIGH_DB_US0 * CLK_MHZ;
    localparam int HIGH_DB_CYC1 = HIGH_DB_US1 * CLK_MHZ;
    localparam int HIGH_DB_CYC2 = HIGH_DB_US2 * CLK_MHZ;
    localparam int HIGH_DB_CYC3 = HIGH_DB_US3 * CLK_MHZ;
    localparam int SETTLE_CYC   = SETTLE_US * CLK_MHZ;
endpackage // vmon_pkg

// File: core/vmon_chan.sv
module vmon_chan #(
    parameter int CNT_W      = vmon_pkg::CNT_W,
    parameter int SETTLE_CYC = vmon_pkg::SETTLE_CYC
) (
    input  logic             clk_i,
    input  logic             rst_b_i,
    input  logic             enable_i,
    input  logic             reg_on_i,
    input  logic             reg_ready_i,
    input  logic             uv_cmp_i,
    input  logic             ov_cmp_i,
    input  logic [CNT_W-1:0] low_db_i,
    input  logic [CNT_W-1:0] high_db_i,
    output logic             uv_s_o,
    output logic             ov_s_o
);
    import vmon_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] low_cnt;
        logic [CNT_W-1:0] high_cnt;
        logic [CNT_W-1:0] settle_cnt;
        logic             settled;
        logic             regulated;
        logic             uv_s;
        logic             ov_s;
    } chan_state_t;

    localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYC - 1);

    chan_state_t r_reg;
    chan_state_t r_next;
    logic        active;

    // monitor live only when enabled, settled and in regulation
    assign active = enable_i && r_reg.settled && r_reg.regulated;
    assign uv_s_o = r_reg.uv_s;
    assign ov_s_o = r_reg.ov_s;

    // settling, regulation masking and debounce
    always_comb begin
        r_next = r_reg;
        if (!enable_i) begin
            r_next.settled    = 1'b0;
            r_next.settle_cnt = '0;
        end else if (!r_reg.settled) begin
            if (r_reg.settle_cnt == SETTLE_LAST) begin
                r_next.settled = 1'b1; // RULE13
            end else begin
                r_next.settle_cnt = r_reg.settle_cnt + CNT_W'(1);
            end
        end
        if (!reg_on_i) begin
            r_next.regulated = 1'b0; // RULE11
        end else if (reg_ready_i) begin
            r_next.regulated = 1'b1;
        end
        if (active && uv_cmp_i) begin
            if (!r_reg.uv_s) begin
                if (r_reg.low_cnt == low_db_i - CNT_W'(1)) begin
                    r_next.uv_s = 1'b1; // RULE15
                end else begin
                    r_next.low_cnt = r_reg.low_cnt + CNT_W'(1);
                end
            end
        end else begin
            r_next.low_cnt = '0; // RULE15
            r_next.uv_s    = 1'b0; // RULE12
        end
        if (active && ov_cmp_i) begin
            if (!r_reg.ov_s) begin
                if (r_reg.high_cnt == high_db_i - CNT_W'(1)) begin
                    r_next.ov_s = 1'b1; // RULE15
                end else begin
                    r_next.high_cnt = r_reg.high_cnt + CNT_W'(1);
                end
            end
        end else begin
            r_next.high_cnt = '0;
            r_next.ov_s     = 1'b0; // RULE12
        end
    end

    // state register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // disabled monitor shows no status
    a_disable_clear: assert property ( // RULE12
        @(posedge clk_i) disable iff (!rst_b_i)
        !enable_i |=> !r_reg.uv_s && !r_reg.ov_s)
        else $error("status kept after monitor disable");

    // no status while settling
    a_settle_blank: assert property ( // RULE13
        @(posedge clk_i) disable iff (!rst_b_i)
        !r_reg.settled |=> !r_reg.uv_s && !r_reg.ov_s)
        else $error("status during settling time");

    // no status before regulation
    a_regulation_mask: assert property ( // RULE11
        @(posedge clk_i) disable iff (!rst_b_i)
        !r_reg.regulated |=> !r_reg.uv_s && !r_reg.ov_s)
        else $error("status before regulation reached");

    // undervoltage set only at debounce expiry
    a_low_debounce: assert property ( // RULE15
        @(posedge clk_i) disable iff (!rst_b_i)
        $rose(r_reg.uv_s) |-> $past(r_reg.low_cnt) == $past(low_db_i) - CNT_W'(1) && $past(uv_cmp_i))
        else $error("undervoltage status set early");

    // overvoltage set only at debounce expiry
    a_high_debounce: assert property ( // RULE15
        @(posedge clk_i) disable iff (!rst_b_i)
        $rose(r_reg.ov_s) |-> $past(r_reg.high_cnt) == $past(high_db_i) - CNT_W'(1) && $past(ov_cmp_i))
        else $error("overvoltage status set early");

    c_uv_set: cover property (@(posedge clk_i) disable iff (!rst_b_i) $rose(r_reg.uv_s));
    c_ov_set: cover property (@(posedge clk_i) disable iff (!rst_b_i) $rose(r_reg.ov_s));
endmodule // vmon_chan

// File: dv/vmon_cmp_model.sv
// behavioural stand-in for the analog comparator bank, one UV/OV pair per regulator
module vmon_cmp_model #(
    parameter int LAG = 0
) (
    input  wire logic                         clk_i,
    input  wire logic [vmon_pkg::NUM_REG-1:0] uv_req_i,
    input  wire logic [vmon_pkg::NUM_REG-1:0] ov_req_i,
    output logic      [vmon_pkg::NUM_REG-1:0] uv_cmp_o,
    output logic      [vmon_pkg::NUM_REG-1:0] ov_cmp_o
);
    timeunit 1ns;
    timeprecision 100ps;
    import vmon_pkg::*;

    logic [NUM_REG-1:0] uv_dly [0:LAG];
    logic [NUM_REG-1:0] ov_dly [0:LAG];

    // slow comparators: the trip shows LAG cycles after the rail crosses
    always_ff @(posedge clk_i) begin
        uv_dly[0] <= uv_req_i;
        ov_dly[0] <= ov_req_i;
        for (int i = 1; i <= LAG; i++) begin
            uv_dly[i] <= uv_dly[i-1];
            ov_dly[i] <= ov_dly[i-1];
        end
    end

    // each regulator has its own independent pair of outputs
    if (LAG == 0) begin : g_direct
        assign uv_cmp_o = uv_req_i;
        assign ov_cmp_o = ov_req_i;
    end else begin : g_lagged
        assign uv_cmp_o = uv_dly[LAG-1];
        assign ov_cmp_o = ov_dly[LAG-1];
    end
endmodule // vmon_cmp_model

// File: dv/vmon_top_tb.sv
module vmon_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import vmon_pkg::*;

    localparam int LDB[4] = '{4, 6, LOW_DB_CYC2, LOW_DB_CYC3};
    localparam int HDB[4] = '{5, 7, HIGH_DB_CYC2, HIGH_DB_CYC3};
    localparam int SET_CYC = 3;

    logic               mclk;
    logic               rst_b;
    logic               wr;
    logic               rd;
    logic               sec_wr;
    logic               sec_en;
    logic [ADDR_W-1:0]  addr;
    logic [DATA_W-1:0]  wdata;
    logic [DATA_W-1:0]  rdata;
    logic [NUM_REG-1:0] reg_on;
    logic [NUM_REG-1:0] reg_ready;
    logic [NUM_REG-1:0] uv_req;
    logic [NUM_REG-1:0] ov_req;
    logic [NUM_REG-1:0] uv_cmp;
    logic [NUM_REG-1:0] ov_cmp;
    logic [NUM_REG-1:0] uv_st;
    logic [NUM_REG-1:0] ov_st;
    logic [15:0]        uv_th;
    logic [15:0]        ov_th;
    logic               irq;
    logic [DATA_W-1:0]  d;
    int                 k;
    int                 err_count = 0;
    int                 n_tests = 0;

    // codes 10 and 11 keep their full lengths, only short codes and settling are scaled
    vmon_top #(.LOW_DB_CYC0(LDB[0]), .LOW_DB_CYC1(LDB[1]),
        .HIGH_DB_CYC0(HDB[0]), .HIGH_DB_CYC1(HDB[1]),
        .SETTLE_CYC(SET_CYC)) u_vmon_top (
        .MCLK_I(mclk), .RST_B_I(rst_b), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .SECURE_WR_I(sec_wr), .SECURE_EN_I(sec_en), .REG_ON_I(reg_on), .REG_READY_I(reg_ready),
        .UV_CMP_I(uv_cmp), .OV_CMP_I(ov_cmp), .RDATA_O(rdata), .UV_TH_O(uv_th), .OV_TH_O(ov_th),
        .UV_STATUS_O(uv_st), .OV_STATUS_O(ov_st), .IRQ_O(irq));

    vmon_cmp_model u_vmon_cmp_model (
        .clk_i(mclk), .uv_req_i(uv_req), .ov_req_i(ov_req), .uv_cmp_o(uv_cmp), .ov_cmp_o(ov_cmp));

    // free-running 200 MHz clock
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] v, input logic s);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        sec_wr <= s;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        sec_wr <= 1'b0;
        #1;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rreg(input logic [7:0] a);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    function automatic logic st_bit(input bit ov, input int r);
        return ov ? ov_st[r] : uv_st[r];
    endfunction

    // raise one comparator, count edges until its status sets, then release it
    task automatic meas(input bit ov, input int r, input int n);
        @(posedge mclk);
        if (ov) ov_req[r] <= 1'b1;
        else uv_req[r] <= 1'b1;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
            #1;
        end while (st_bit(ov, r) !== 1'b1 && k < n + 40);
        chk(k, n);
        chk({ov_st, uv_st}, 16'h1 << (r + 8 * ov));
        @(posedge mclk);
        ov_req[r] <= 1'b0;
        uv_req[r] <= 1'b0;
        @(posedge mclk);
        #1 chk({ov_st, uv_st}, 16'h0);
    endtask

    task automatic t_reset;
        rreg(ENABLE_OFS);
        chk(d, 32'h0000_00ff);
        rreg(DEBOUNCE_OFS);
        chk(d, 32'h0000_0002);
        chk({ov_th, uv_th}, 32'h0);
        chk({16'h0, ov_st, uv_st}, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_thresh;
        for (int c = 0; c < 4; c++) begin
            wreg(THRESH_OFS, {{8{2'(3 - c)}}, {8{2'(c)}}}, 1'b0);
            chk({ov_th, uv_th}, {{8{2'(3 - c)}}, {8{2'(c)}}});
        end
        wreg(THRESH_OFS, 32'he4e4_1b1b, 1'b0);
        chk({ov_th, uv_th}, 32'he4e4_1b1b);
        rreg(THRESH_OFS);
        chk(d, 32'he4e4_1b1b);
        $display("test thresholds done");
    endtask

    task automatic t_debounce;
        for (int s = 0; s < 4; s++) begin
            wreg(DEBOUNCE_OFS, 32'(s * 5), 1'b0);
            meas(1'b0, 0, LDB[s]);
            meas(1'b1, 7, HDB[s]);
        end
        // a one-cycle drop just short of expiry restarts the count
        wreg(DEBOUNCE_OFS, 32'h0000_0005, 1'b0);
        @(posedge mclk);
        uv_req[1] <= 1'b1;
        repeat (LDB[1] - 1) @(posedge mclk);
        uv_req[1] <= 1'b0;
        meas(1'b0, 1, LDB[1]);
        $display("test debounce done");
    endtask

    task automatic t_secure;
        wreg(DEBOUNCE_OFS, 32'h0, 1'b0);
        @(posedge mclk);
        sec_en <= 1'b1;
        uv_req[2] <= 1'b1;
        repeat (LDB[0] + 2) @(posedge mclk);
        #1 chk(uv_st[2], 1'b1);
        wreg(ENABLE_OFS, 32'h0000_00fb, 1'b0);
        rreg(ENABLE_OFS);
        chk(d, 32'h0000_00ff);
        chk(uv_st[2], 1'b1);
        wreg(ENABLE_OFS, 32'h0000_00fb, 1'b1);
        @(posedge mclk);
        #1 chk(uv_st[2], 1'b0);
        rreg(ENABLE_OFS);
        chk(d, 32'h0000_00fb);
        repeat (20) @(posedge mclk);
        #1 chk(uv_st[2], 1'b0);
        wreg(ENABLE_OFS, 32'h0000_00ff, 1'b1);
        k = 0;
        while (uv_st[2] !== 1'b1 && k < 40) begin
            @(posedge mclk);
            k++;
            #1;
        end
        chk(k > SET_CYC, 1'b1);
        chk(k <= SET_CYC + LDB[0] + 3, 1'b1);
        @(posedge mclk);
        uv_req[2] <= 1'b0;
        sec_en <= 1'b0;
        $display("test secure enable done");
    endtask

    task automatic t_regon;
        @(posedge mclk);
        reg_on[3] <= 1'b0;
        reg_ready[3] <= 1'b0;
        uv_req[3] <= 1'b1;
        repeat (20) @(posedge mclk);
        #1 chk(uv_st[3], 1'b0);
        @(posedge mclk);
        reg_on[3] <= 1'b1;
        repeat (20) @(posedge mclk);
        #1 chk(uv_st[3], 1'b0);
        @(posedge mclk);
        reg_ready[3] <= 1'b1;
        k = 0;
        while (uv_st[3] !== 1'b1 && k < 40) begin
            @(posedge mclk);
            k++;
            #1;
        end
        chk(k >= LDB[0] && k <= LDB[0] + 3, 1'b1);
        @(posedge mclk);
        uv_req[3] <= 1'b0;
        $display("test regulation mask done");
    endtask

    task automatic t_irq;
        repeat (3) @(posedge mclk);
        rreg(IRQ_STAT_OFS);
        chk(d, 32'h0000_800f);
        chk(irq, 1'b0);
        wreg(IRQ_MASK_OFS, 32'h0000_0001, 1'b0);
        chk(irq, 1'b1);
        wreg(IRQ_STAT_OFS, 32'h0000_0001, 1'b0);
        chk(irq, 1'b0);
        rreg(IRQ_STAT_OFS);
        chk(d, 32'h0000_800e);
        wreg(STATUS_OFS, 32'h0000_ffff, 1'b0);
        rreg(STATUS_OFS);
        chk(d, 32'h0);
        rreg(8'h40);
        chk(d, 32'h0);
        $display("test interrupt done");
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // watchdog: the full-length debounce codes bring the run to about 54000 cycles
    initial begin
        repeat (80000) @(posedge mclk);
        err_count++;
        give_verdict();
    end

    // main sequence
    initial begin
        rst_b = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        sec_wr = 1'b0;
        sec_en = 1'b0;
        addr = '0;
        wdata = '0;
        reg_on = '1;
        reg_ready = '1;
        uv_req = '0;
        ov_req = '0;
        repeat (10) @(posedge mclk);
        rst_b <= 1'b1;
        t_reset();
        t_thresh();
        t_debounce();
        t_secure();
        t_regon();
        t_irq();
        give_verdict();
    end
endmodule // vmon_top_tb
